// ==== include/ibc_pkg.sv ====
// package for the i2c clock and data register block
// assumes a single core clock domain and a plain register port
package ibc_pkg;
  localparam int unsigned CORE_CLK_HZ = 40_000_000;
  localparam logic [3:0] ADDR_SPEED = 4'h0;
  localparam logic [3:0] ADDR_BYTE = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h6;
  localparam logic [7:0] SPEED_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int SPEED_MODE_BIT = 7;
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_TX_BIT = 1;
  localparam int CTRL_ACK_BIT = 2;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_NACK_BIT = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_NACK_BIT = 1;
  // half period base and step per divider count, in core cycles
  localparam logic [11:0] STD_HALF_BASE = 12'h00a;
  localparam logic [11:0] STD_HALF_STEP = 12'h004;
  localparam logic [11:0] FAST_HALF_BASE = 12'h004;
  localparam logic [11:0] FAST_HALF_STEP = 12'h001;
  localparam logic [3:0] BIT_LAST = 4'h8;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ibc_bus_s;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } ibc_pin_s;
endpackage : ibc_pkg

// ==== design/ibc_scl_gen.sv ====
// scl tick generator for the i2c byte engine
// assumes the engine asks for ticks only while a byte moves
`timescale 1ns/1ps
`default_nettype none
module ibc_scl_gen
  import ibc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // control
  input wire logic i_run,
  input wire logic i_fast,
  input wire logic [6:0] i_divider,
  // tick out
  output logic o_tick
);
  logic [11:0] cnt_reg;
  logic [11:0] half_next;

  // R11 per mode formulas
  always_comb begin
    if (i_fast) begin
      half_next = FAST_HALF_BASE + FAST_HALF_STEP * {5'h00, i_divider};
    end else begin
      half_next = STD_HALF_BASE + STD_HALF_STEP * {5'h00, i_divider};
    end
  end

  // R3 divider sets rate
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_reg <= 12'h000;
    end else if (!i_run || cnt_reg >= half_next) begin
      cnt_reg <= 12'h000;
    end else begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end

  assign o_tick = i_run && (cnt_reg >= half_next);
endmodule : ibc_scl_gen
`default_nettype wire

// ==== design/ibc_core.sv ====
// i2c speed setting and byte buffer with a simple byte engine
// assumes start, stop and addressing are handled by a sibling block
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: speed bit 7 software only, fast/standard
// R2: speed bit kept when interface off
// R3: bits 6:0 divider set scl rate
// R4: divider kept when interface off
// R5: byte buffer eight bits, both reset zero
// R6: byte buffer write starts transmit
// R7: first received byte lands automatically; the code starts even the first byte only on a byte buffer read
// R8: further bytes only after buffer read
// R9: status read then buffer access clears done
// R10: scl held low while done set
// R11: separate parameterised scl formulas per mode
module ibc_core
  import ibc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_scl_oe,
  output logic o_sda,
  output logic o_sda_oe,
  // interrupt
  output logic o_irq
);
  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_ACK_LOW, ST_ACK_HIGH, ST_HOLD} ibc_st_e;

  ibc_bus_s bus;
  ibc_pin_s pin_reg;
  ibc_st_e st_reg;
  logic [7:0] speed_reg;
  logic [7:0] byte_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic [2:0] ctrl_reg;
  logic done_reg;
  logic nack_reg;
  logic stat_seen_reg;
  logic rx_pending_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_en_reg;
  logic [7:0] rdata_reg;
  logic tick;
  logic on;
  logic tx_mode;
  logic wr_byte;
  logic rd_byte;
  logic rd_stat;
  logic done_set;
  logic done_clr;
  logic nack_set;
  logic start_tx;
  logic start_rx;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign on = ctrl_reg[CTRL_ON_BIT];
  assign tx_mode = ctrl_reg[CTRL_TX_BIT];
  assign wr_byte = bus.wr && bus.addr == ADDR_BYTE;
  assign rd_byte = bus.rd && bus.addr == ADDR_BYTE;
  assign rd_stat = bus.rd && bus.addr == ADDR_STAT;

  //////////////////////////////////////////////////////////////////////
  ibc_scl_gen u_scl_gen (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(on && st_reg != ST_IDLE && st_reg != ST_HOLD),
    .i_fast(speed_reg[SPEED_MODE_BIT]),
    .i_divider(speed_reg[6:0]),
    .o_tick(tick)
  );

  //////////////////////////////////////////////////////////////////////
  // R1 software owned speed
  // R2 kept when off
  // R4 divider not cleared
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      speed_reg <= SPEED_RESET;
    end else if (bus.wr && bus.addr == ADDR_SPEED) begin
      speed_reg <= bus.wdata;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg <= 3'h0;
    end else if (bus.wr && bus.addr == ADDR_CTRL) begin
      ctrl_reg <= bus.wdata[2:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // R5 byte buffer reset zero
  // R7 received byte captured
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      byte_reg <= BYTE_RESET;
    end else if (wr_byte) begin
      byte_reg <= bus.wdata;
    end else if (!tx_mode && st_reg == ST_ACK_LOW && tick) begin
      byte_reg <= shift_reg;
    end
  end

  // R9 status read arms clear
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stat_seen_reg <= 1'b0;
    end else if (!on || done_clr) begin
      stat_seen_reg <= 1'b0;
    end else if (rd_stat && done_reg) begin
      stat_seen_reg <= 1'b1;
    end
  end

  assign done_set = on && st_reg == ST_ACK_HIGH && tick;
  assign done_clr = stat_seen_reg && (wr_byte || rd_byte);
  assign nack_set = done_set && tx_mode && i_sda;

  // R9 done cleared by sequence, set wins
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_reg <= 1'b0;
    end else if (done_set) begin
      done_reg <= 1'b1;
    end else if (!on || done_clr) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      nack_reg <= 1'b0;
    end else if (nack_set) begin
      nack_reg <= 1'b1;
    end else if (!on || done_clr) begin
      nack_reg <= 1'b0;
    end
  end

  // R8 next byte waits for read
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_pending_reg <= 1'b0;
    end else if (!on || tx_mode) begin
      rx_pending_reg <= 1'b0;
    end else if (rd_byte) begin
      rx_pending_reg <= 1'b1;
    end else if (st_reg == ST_LOW) begin
      rx_pending_reg <= 1'b0;
    end
  end

  // R6 write launches transmit
  assign start_tx = on && tx_mode && wr_byte;
  // R7 first rx byte starts on a byte buffer read
  assign start_rx = on && !tx_mode && (rd_byte || rx_pending_reg);

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (!on) begin
      st_reg <= ST_IDLE;
      bit_reg <= 4'h0;
    end else begin
      unique case (st_reg)
        ST_IDLE, ST_HOLD: begin
          // hold until software services the buffer
          if (start_tx) begin
            st_reg <= ST_LOW;
            shift_reg <= bus.wdata;
            bit_reg <= 4'h0;
          end else if (start_rx && !done_reg) begin
            st_reg <= ST_LOW;
            bit_reg <= 4'h0;
          end
        end
        ST_LOW: begin
          if (tick) begin
            st_reg <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          // slave stretching: wait for scl to really rise
          if (tick && i_scl) begin
            shift_reg <= {shift_reg[6:0], tx_mode ? 1'b1 : i_sda};
            bit_reg <= bit_reg + 4'h1;
            st_reg <= (bit_reg + 4'h1 == BIT_LAST) ? ST_ACK_LOW : ST_LOW;
          end
        end
        ST_ACK_LOW: begin
          if (tick) begin
            st_reg <= ST_ACK_HIGH;
          end
        end
        ST_ACK_HIGH: begin
          if (tick && i_scl) begin
            st_reg <= ST_HOLD;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // R10 scl low while done
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_reg <= '{scl_o: 1'b0, scl_oe: 1'b0, sda_o: 1'b0, sda_oe: 1'b0};
    end else begin
      pin_reg.scl_o <= 1'b0;
      // hold scl low in the restart gap too, or a stray scl pulse slips out
      pin_reg.scl_oe <= on && (done_reg || st_reg == ST_LOW || st_reg == ST_ACK_LOW ||
                               st_reg == ST_HOLD);
      pin_reg.sda_o <= 1'b0;
      if (st_reg == ST_LOW || st_reg == ST_HIGH) begin
        pin_reg.sda_oe <= on && tx_mode && !shift_reg[7];
      end else if (st_reg == ST_ACK_LOW || st_reg == ST_ACK_HIGH) begin
        pin_reg.sda_oe <= on && !tx_mode && ctrl_reg[CTRL_ACK_BIT];
      end else begin
        pin_reg.sda_oe <= 1'b0;
      end
    end
  end

  assign o_scl = pin_reg.scl_o;
  assign o_scl_oe = pin_reg.scl_oe;
  assign o_sda = pin_reg.sda_o;
  assign o_sda_oe = pin_reg.sda_oe;

  //////////////////////////////////////////////////////////////////////
  // sticky events, set beats clear
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_stat_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == IRQ_DONE_BIT && done_set) || (i == IRQ_NACK_BIT && nack_set)) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (bus.wr && bus.addr == ADDR_IRQ_CLR && bus.wdata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_en_reg <= 2'h0;
    end else if (bus.wr && bus.addr == ADDR_IRQ_EN) begin
      irq_en_reg <= bus.wdata[1:0];
    end
  end

  assign o_irq = |(irq_stat_reg & irq_en_reg);

  //////////////////////////////////////////////////////////////////////
  // unmapped reads return zero
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_SPEED: rdata_reg <= speed_reg;
        ADDR_BYTE: rdata_reg <= byte_reg;
        ADDR_CTRL: rdata_reg <= {5'h00, ctrl_reg};
        ADDR_STAT: rdata_reg <= {5'h00, nack_reg, st_reg != ST_IDLE && st_reg != ST_HOLD,
                                 done_reg};
        ADDR_IRQ_STAT: rdata_reg <= {6'h00, irq_stat_reg};
        ADDR_IRQ_EN: rdata_reg <= {6'h00, irq_en_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign o_rdata = rdata_reg;
endmodule : ibc_core
`default_nettype wire

// ==== verification/ibc_core_monitor.sv ====
// assertion checker for the speed and byte block, bound to its top ports
// assumes one core clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ibc_core_monitor
  import ibc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // pins and interrupt
  input wire logic o_scl,
  input wire logic o_scl_oe,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic [7:0] spd_reg;
  logic [1:0] en_reg;
  // shadow copies, so readback and masking are judged against software writes
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      spd_reg <= SPEED_RESET;
      en_reg <= 2'h0;
    end else begin
      if (i_wr && i_addr == ADDR_SPEED) spd_reg <= i_wdata;
      if (i_wr && i_addr == ADDR_IRQ_EN) en_reg <= i_wdata[1:0];
    end
  end
  a_speed_readback: assert property (
    i_rd && i_addr == ADDR_SPEED |=> o_rdata == spd_reg) else $error("speed readback wrong");
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data without read");
  a_unmapped_zero: assert property (
    i_rd && i_addr > ADDR_IRQ_CLR |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  a_pins_open_drain: assert property (
    o_scl == 1'b0 && o_sda == 1'b0) else $error("pin driven high");
  a_reset_quiet: assert property (
    $fell(i_sys_rst) |-> !o_scl_oe && !o_sda_oe && !o_irq) else $error("busy after reset");
  a_scl_half_min: assert property (
    $rose(o_scl_oe) |=> $stable(o_scl_oe)[*3]) else $error("scl low too short");
  a_sda_under_low: assert property (
    $changed(o_sda_oe) |-> o_scl_oe) else $error("sda moved with scl high");
  a_irq_masked: assert property (
    en_reg == 2'h0 |-> !o_irq) else $error("irq while masked");
  a_irq_status: assert property (
    i_rd && i_addr == ADDR_IRQ_STAT && o_irq |=> o_rdata != 8'h00) else $error("irq no cause");
  a_done_stretch: assert property (
    i_rd && i_addr == ADDR_STAT ##1 o_rdata[STAT_DONE_BIT] |-> o_scl_oe) else $error("no stretch");
  c_byte_write: cover property (i_wr && i_addr == ADDR_BYTE);
  c_irq_rise: cover property ($rose(o_irq));
  c_done_seen: cover property (i_rd && i_addr == ADDR_STAT ##1 o_rdata[STAT_DONE_BIT]);
endmodule : ibc_core_monitor
bind ibc_core ibc_core_monitor u_ibc_core_monitor (.i_core_clk, .i_sys_rst, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_scl, .o_scl_oe, .o_sda, .o_sda_oe, .o_irq);
`default_nettype wire

// ==== verification/ibc_bus_partner.sv ====
// far-side target: acks bytes it receives, returns bytes msb first
// assumes pulled-up lines, sampled on the core clock
`timescale 1ns/1ps
`default_nettype none
module ibc_bus_partner (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // line level and mode
  input wire logic i_scl,
  input wire logic i_rx,
  input wire logic [7:0] i_byte,
  input wire logic i_no_ack,
  // data pull-down
  output logic o_sda_oe
);
  logic scl_q;
  logic [3:0] rise_cnt;
  logic [3:0] slot;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_q <= 1'b1;
      rise_cnt <= 4'h0;
      slot <= 4'h0;
    end else begin
      scl_q <= i_scl;
      if (i_scl && !scl_q) rise_cnt <= (rise_cnt == 4'h8) ? 4'h0 : rise_cnt + 4'h1;
      // slot moves on falling scl only, so sda never moves while scl is high
      if (!i_scl && scl_q) slot <= rise_cnt;
    end
  end
  assign o_sda_oe = i_rx ? (slot < 4'h8 && !i_byte[3'h7 - slot[2:0]]) :
                    (slot == 4'h8 && !i_no_ack);
endmodule : ibc_bus_partner
`default_nettype wire

// ==== verification/ibc_core_bench.sv ====
// self-checking bench: register port, transmit and receive bytes
// assumes the partner model on the wire and pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
module ibc_core_bench
  import ibc_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic rx_mode = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic no_ack = 1'b0;
  logic [7:0] o_rdata;
  logic o_scl, o_scl_oe, o_sda, o_sda_oe, o_irq, p_sda_oe;
  wire scl_l = !o_scl_oe;
  wire sda_l = !(o_sda_oe || p_sda_oe);
  int err_count = 0;
  int check_count = 0;
  logic scl_q = 1'b1;
  logic [8:0] cap = 9'h000;
  logic [15:0] rises = 16'h0000;
  logic [15:0] gap = 16'h0000;
  logic [15:0] per = 16'h0000;
  ibc_core u_ibc_core (.i_core_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_scl(scl_l), .i_sda(sda_l), .o_scl, .o_scl_oe, .o_sda, .o_sda_oe, .o_irq);
  ibc_bus_partner u_ibc_bus_partner (.i_core_clk, .i_sys_rst, .i_scl(scl_l), .i_rx(rx_mode),
    .i_byte(rx_byte), .i_no_ack(no_ack), .o_sda_oe(p_sda_oe));
  initial forever #12.5 i_core_clk = ~i_core_clk;
  // wire watcher: bits at scl rise, period between rises
  always @(posedge i_core_clk) begin
    scl_q <= scl_l;
    gap <= gap + 16'h0001;
    if (scl_l && !scl_q) begin
      cap <= {cap[7:0], sda_l};
      rises <= rises + 16'h0001;
      per <= gap + 16'h0001;
      gap <= 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task automatic wait_done();
    logic [7:0] s = 8'h00;
    for (int n = 0; n < 300 && !s[STAT_DONE_BIT]; n++) rd(ADDR_STAT, s);
    chk(s[STAT_DONE_BIT], 1'b1);
  endtask : wait_done
  function automatic logic [15:0] half2(input logic [7:0] sp);
    logic [15:0] h;
    h = sp[7] ? 16'(FAST_HALF_BASE + sp[6:0] * FAST_HALF_STEP)
      : 16'(STD_HALF_BASE + sp[6:0] * STD_HALF_STEP);
    // each phase spans the half count plus the tick cycle
    return 16'(2 * (h + 16'h0001));
  endfunction : half2
  task automatic conclude();
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge i_core_clk);
    err_count++;
    conclude();
  end
  initial begin
    logic [7:0] s;
    logic [7:0] b;
    logic [7:0] prev;
    logic [15:0] r0;
    void'($urandom(32'hcbdd));
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd(ADDR_SPEED, s);
    chk(s, SPEED_RESET);
    rd(ADDR_BYTE, s);
    chk(s, BYTE_RESET);
    for (int k = 0; k < 6; k++) begin
      b = (k == 0) ? 8'h7f : ((k == 1) ? 8'h80 : 8'($urandom));
      wr(ADDR_SPEED, b);
      if (k == 5) wr(ADDR_CTRL, 8'h01);
      if (k == 5) wr(ADDR_CTRL, 8'h00);
      rd(ADDR_SPEED, s);
      chk(s, b);
    end
    b = 8'($urandom);
    wr(ADDR_BYTE, b);
    rd(ADDR_BYTE, s);
    chk(s, b);
    for (int a = 7; a < 16; a++) begin
      wr(4'(a), 8'hff);
      rd(4'(a), s);
      chk(s, 8'h00);
    end
    wr(ADDR_IRQ_EN, 8'h01);
    wr(ADDR_CTRL, 8'h03);
    for (int k = 0; k < 3; k++) begin
      b = 8'($urandom);
      wr(ADDR_SPEED, k ? 8'h01 : 8'h82);
      no_ack <= (k == 2);
      r0 = rises;
      rd(ADDR_STAT, s);
      wr(ADDR_BYTE, b);
      rd(ADDR_STAT, s);
      chk(s[STAT_DONE_BIT], 1'b0);
      chk(s[STAT_BUSY_BIT], 1'b1);
      wait_done();
      chk(cap[8:1], b);
      chk(cap[0], k == 2);
      chk(per, half2(k ? 8'h01 : 8'h82));
      chk(o_irq, 1'b1);
      rd(ADDR_STAT, s);
      chk(s[STAT_NACK_BIT], k == 2);
      rd(ADDR_IRQ_STAT, s);
      chk(s[IRQ_NACK_BIT], k == 2);
      repeat (20) @(posedge i_core_clk);
      chk(scl_l, 1'b0);
      chk(rises - r0, 16'h0009);
    end
    no_ack <= 1'b0;
    wr(ADDR_IRQ_CLR, 8'h03);
    #1 chk(o_irq, 1'b0);
    wr(ADDR_IRQ_EN, 8'h00);
    wr(ADDR_CTRL, 8'h05);
    rx_mode <= 1'b1;
    prev = 8'h00;
    for (int k = 0; k < 3; k++) begin
      b = 8'($urandom);
      rx_byte <= b;
      r0 = rises;
      rd(ADDR_STAT, s);
      rd(ADDR_BYTE, s);
      if (k > 0) chk(s, prev);
      prev = b;
      wait_done();
      chk(o_irq, 1'b0);
      chk(cap[0], 1'b0);
      repeat (20) @(posedge i_core_clk);
      chk(rises - r0, 16'h0009);
    end
    rd(ADDR_STAT, s);
    rd(ADDR_BYTE, s);
    chk(s, prev);
    conclude();
  end
endmodule : ibc_core_bench
`default_nettype wire
